// >>> tsq_pkg.sv
// Constants and types for the target and signal query command interpreter
package tsq_pkg;

  // Framing, digit and letter-case characters
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [7:0] CHAR_ACK = 8'h3E;
  localparam logic [7:0] CHAR_NAK = 8'h3F;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] CHAR_LOW_A = 8'h61;
  localparam logic [7:0] CHAR_LOW_Z = 8'h7A;
  localparam logic [7:0] CASE_GAP = 8'h20;

  // Command buffer depth in characters; longest keyword is 11
  localparam int CMD_MAX = 12;

  // Keywords as upper-case ASCII, matched against the last characters held
  localparam logic [8*11-1:0] KW_TARGET = 88'h5447544C4F434154494F4E;
  localparam logic [8*8-1:0] KW_RF = 64'h5349474C4556454C;
  localparam logic [8*10-1:0] KW_QUALITY = 80'h5349475155414C495459;
  localparam logic [8*7-1:0] KW_KIND = 56'h49524454595045;
  localparam logic [3:0] KW_TARGET_LEN = 4'hB;
  localparam logic [3:0] KW_RF_LEN = 4'h8;
  localparam logic [3:0] KW_QUALITY_LEN = 4'hA;
  localparam logic [3:0] KW_KIND_LEN = 4'h7;

  // Reply text pieces
  localparam logic [8*20-1:0] TXT_TARGET = "Target Location = E ";
  localparam logic [8*4-1:0] TXT_SEP = ", A ";
  localparam logic [8*18-1:0] TXT_RF = "Signal Strength = ";
  localparam logic [8*23-1:0] TXT_QUALITY = "Stale Signal Quality = ";
  localparam logic [8*14-1:0] TXT_KIND = "Receiver type ";
  localparam logic [8*23-1:0] TXT_KIND_STATE [4] = '{
    "has not been tested yet", "is protocol A",
    "is protocol B", "cannot be determined"};
  localparam int KIND_STATE_LEN [4] = '{23, 13, 13, 20};

  // Body lengths of fixed-format replies
  localparam int LEN_TARGET = 31;
  localparam int LEN_RF = 22;
  localparam int LEN_QUALITY = 25;
  localparam int LEN_KIND_PREFIX = 14;

  // Numeric field limits and calibration scaling
  localparam logic [13:0] DEC4_MAX = 14'h270F;
  localparam logic [13:0] DEC3_MAX = 14'h03E7;
  localparam logic [7:0] DEC2_MAX = 8'h63;
  localparam int GAIN_FRAC = 8;

  // Reset values
  localparam logic [15:0] BCD_RESET = 16'h0000;
  localparam logic [7:0] POS_RESET = 8'h00;

  typedef enum logic [2:0] {
    TSQ_CMD_NONE = 3'b000,
    TSQ_CMD_TARGET = 3'b001,
    TSQ_CMD_RF = 3'b010,
    TSQ_CMD_QUALITY = 3'b011,
    TSQ_CMD_KIND = 3'b100
  } tsq_cmd_t;

  typedef enum logic [0:0] {
    TSQ_ST_RECV = 1'b0,
    TSQ_ST_SEND = 1'b1
  } tsq_state_t;

  typedef enum logic [1:0] {
    TSQ_KIND_UNTESTED = 2'b00,
    TSQ_KIND_PROTO_A = 2'b01,
    TSQ_KIND_PROTO_B = 2'b10,
    TSQ_KIND_UNKNOWN = 2'b11
  } tsq_kind_t;

endpackage

// >>> tsq_query_cmds.sv
// Maintenance-port parser for the target and signal query commands

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Parse buffered command only on carriage return; line feeds are dropped.
// - Every reply ends CR, LF, then acknowledge or not-acknowledge character.
// - Keywords match regardless of letter case.
// - Target query reports saved position: elevation field, then azimuth.
// - Signal-level query reports detector reading with gain and offset applied.
// - Quality query replies at once with last receiver value, labelled stale.
// - Each quality query sends a fresh quality request to the receiver.
// - Receiver-kind query reports untested, protocol A, protocol B or unknown.
module tsq_query_cmds (
  input wire logic clk_sys, // System clock, 10 MHz
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic [7:0] rx_data, // Terminal character in
  input wire logic rx_valid, // Terminal character present
  output logic rx_ready, // Parser can take a character
  output logic [7:0] tx_data, // Reply character out
  output logic tx_valid, // Reply character present
  input wire logic tx_ready, // Serial port takes the character
  input wire logic [13:0] target_el, // Saved elevation, tenths of degree
  input wire logic [13:0] target_az, // Saved azimuth, tenths of degree
  input wire logic [11:0] rf_raw, // Raw RF power detector reading
  input wire logic [15:0] rf_gain, // Calibration gain, 8 fraction bits
  input wire logic signed [13:0] rf_offset, // Calibration offset
  input wire logic [7:0] quality_last, // Last quality value from receiver
  input wire logic [1:0] receiver_kind, // Detected receiver kind code
  output logic quality_req // Pulse: ask receiver for new quality
);

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Double-dabble conversion of a value no larger than 9999
  function automatic logic [15:0] to_bcd(input logic [13:0] bin);
    logic [29:0] sh;
    sh = {16'h0000, bin};
    for (int i = 0; i < 14; i++)
    begin
      for (int d = 0; d < 4; d++)
      begin
        if (sh[14 + 4 * d +: 4] > 4'h4)
          sh[14 + 4 * d +: 4] = sh[14 + 4 * d +: 4] + 4'h3;
      end
      sh = {sh[28:0], 1'b0};
    end
    return sh[29:14];
  endfunction

  // ASCII digit k (0 = most significant) of an n-digit field
  function automatic logic [7:0] digit(input logic [15:0] bcd, input int n,
                                       input int k);
    return tsq_pkg::CHAR_ZERO + {4'h0, bcd[4 * (n - 1 - k) +: 4]};
  endfunction

  // Reply character at a position; body, then CR, LF, ack or nak
  function automatic logic [7:0] reply_char(
    input tsq_pkg::tsq_cmd_t cmd, input int p, input logic [15:0] el,
    input logic [15:0] az, input logic [15:0] lvl, input logic [15:0] q,
    input logic [1:0] kind);
    int blen;
    logic [7:0] ch;
    blen = 0;
    ch = 8'h00;
    case (cmd)
      tsq_pkg::TSQ_CMD_TARGET:
      begin
        blen = tsq_pkg::LEN_TARGET;
        if (p < 20)
          ch = tsq_pkg::TXT_TARGET[8 * (19 - p) +: 8];
        else if (p < 23)
          ch = digit(el, 3, p - 20);
        else if (p < 27)
          ch = tsq_pkg::TXT_SEP[8 * (26 - p) +: 8];
        else if (p < 31)
          ch = digit(az, 4, p - 27);
      end
      tsq_pkg::TSQ_CMD_RF:
      begin
        blen = tsq_pkg::LEN_RF;
        if (p < 18)
          ch = tsq_pkg::TXT_RF[8 * (17 - p) +: 8];
        else if (p < 22)
          ch = digit(lvl, 4, p - 18);
      end
      tsq_pkg::TSQ_CMD_QUALITY:
      begin
        blen = tsq_pkg::LEN_QUALITY;
        if (p < 23)
          ch = tsq_pkg::TXT_QUALITY[8 * (22 - p) +: 8];
        else if (p < 25)
          ch = digit(q, 2, p - 23);
      end
      tsq_pkg::TSQ_CMD_KIND:
      begin
        blen = tsq_pkg::LEN_KIND_PREFIX + tsq_pkg::KIND_STATE_LEN[kind];
        if (p < 14)
          ch = tsq_pkg::TXT_KIND[8 * (13 - p) +: 8];
        else if (p < blen)
          ch = tsq_pkg::TXT_KIND_STATE[kind][8 * (blen - 1 - p) +: 8];
      end
      default:
        blen = 0;
    endcase
    // Closing sequence shared by every reply
    if (p == blen)
      ch = tsq_pkg::CHAR_CR;
    else if (p == blen + 1)
      ch = tsq_pkg::CHAR_LF;
    else if (p == blen + 2)
      ch = (cmd == tsq_pkg::TSQ_CMD_NONE) ? tsq_pkg::CHAR_NAK
                                          : tsq_pkg::CHAR_ACK;
    return ch;
  endfunction

  // Last position of a reply
  function automatic int reply_last(input tsq_pkg::tsq_cmd_t cmd,
                                    input logic [1:0] kind);
    int blen;
    blen = 0;
    case (cmd)
      tsq_pkg::TSQ_CMD_TARGET: blen = tsq_pkg::LEN_TARGET;
      tsq_pkg::TSQ_CMD_RF: blen = tsq_pkg::LEN_RF;
      tsq_pkg::TSQ_CMD_QUALITY: blen = tsq_pkg::LEN_QUALITY;
      tsq_pkg::TSQ_CMD_KIND:
        blen = tsq_pkg::LEN_KIND_PREFIX + tsq_pkg::KIND_STATE_LEN[kind];
      default: blen = 0;
    endcase
    return blen + 2;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State

  tsq_pkg::tsq_state_t state, next_state;
  tsq_pkg::tsq_cmd_t cmd, next_cmd;
  logic [8 * tsq_pkg::CMD_MAX - 1:0] cmd_buf, next_cmd_buf;
  logic [3:0] cmd_len, next_cmd_len;
  logic [7:0] pos, next_pos;
  logic [15:0] el_bcd, next_el_bcd;
  logic [15:0] az_bcd, next_az_bcd;
  logic [15:0] lvl_bcd, next_lvl_bcd;
  logic [15:0] q_bcd, next_q_bcd;
  logic [1:0] kind, next_kind;
  logic [7:0] next_tx_data;
  logic next_quality_req;
  logic [7:0] ch_up;
  logic take;
  logic [27:0] rf_prod;
  logic signed [21:0] rf_cal;
  logic [13:0] rf_clamped;
  tsq_pkg::tsq_cmd_t parsed;

  // Input accepted only between replies; the terminal waits on ready
  assign rx_ready = (state == tsq_pkg::TSQ_ST_RECV);
  assign tx_valid = (state == tsq_pkg::TSQ_ST_SEND);
  assign take = rx_valid && rx_ready;

  // Fold lower case onto upper case before storing
  always_comb
  begin
    ch_up = rx_data;
    if (rx_data >= tsq_pkg::CHAR_LOW_A && rx_data <= tsq_pkg::CHAR_LOW_Z)
      ch_up = rx_data - tsq_pkg::CASE_GAP;
  end

  // Calibrated RF level, clamped to the four-digit field
  always_comb
  begin
    rf_prod = {16'h0000, rf_raw} * {12'h000, rf_gain};
    rf_cal = $signed({2'b00, rf_prod[27:tsq_pkg::GAIN_FRAC]}) +
             22'(rf_offset);
    if (rf_cal < 0)
      rf_clamped = 14'h0000;
    else if (rf_cal > $signed({8'h00, tsq_pkg::DEC4_MAX}))
      rf_clamped = tsq_pkg::DEC4_MAX;
    else
      rf_clamped = rf_cal[13:0];
  end

  // Whole-buffer keyword match; trailing argument text breaks the length test
  always_comb
  begin
    parsed = tsq_pkg::TSQ_CMD_NONE;
    if (cmd_len == tsq_pkg::KW_TARGET_LEN && cmd_buf[87:0] == tsq_pkg::KW_TARGET)
      parsed = tsq_pkg::TSQ_CMD_TARGET;
    else if (cmd_len == tsq_pkg::KW_RF_LEN && cmd_buf[63:0] == tsq_pkg::KW_RF)
      parsed = tsq_pkg::TSQ_CMD_RF;
    else if (cmd_len == tsq_pkg::KW_QUALITY_LEN &&
             cmd_buf[79:0] == tsq_pkg::KW_QUALITY)
      parsed = tsq_pkg::TSQ_CMD_QUALITY;
    else if (cmd_len == tsq_pkg::KW_KIND_LEN && cmd_buf[55:0] == tsq_pkg::KW_KIND)
      parsed = tsq_pkg::TSQ_CMD_KIND;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Parser and reply sequencer

  // Next-state logic; data fields are captured at the CR so a reply is coherent
  always_comb
  begin
    next_state = state;
    next_cmd = cmd;
    next_cmd_buf = cmd_buf;
    next_cmd_len = cmd_len;
    next_pos = pos;
    next_el_bcd = el_bcd;
    next_az_bcd = az_bcd;
    next_lvl_bcd = lvl_bcd;
    next_q_bcd = q_bcd;
    next_kind = kind;
    next_quality_req = 1'b0;
    case (state)
      tsq_pkg::TSQ_ST_RECV:
      begin
        if (take && rx_data == tsq_pkg::CHAR_CR)
        begin
          next_state = tsq_pkg::TSQ_ST_SEND;
          next_cmd = parsed;
          next_pos = tsq_pkg::POS_RESET;
          next_cmd_len = 4'h0;
          next_el_bcd = to_bcd((target_el > tsq_pkg::DEC3_MAX) ?
                               tsq_pkg::DEC3_MAX : target_el);
          next_az_bcd = to_bcd((target_az > tsq_pkg::DEC4_MAX) ?
                               tsq_pkg::DEC4_MAX : target_az);
          next_lvl_bcd = to_bcd(rf_clamped);
          next_q_bcd = to_bcd({6'h00, (quality_last > tsq_pkg::DEC2_MAX) ?
                               tsq_pkg::DEC2_MAX : quality_last});
          next_kind = receiver_kind;
          next_quality_req = (parsed == tsq_pkg::TSQ_CMD_QUALITY);
        end
        else if (take && rx_data != tsq_pkg::CHAR_LF)
        begin
          next_cmd_buf = {cmd_buf[8 * tsq_pkg::CMD_MAX - 9:0], ch_up};
          if (cmd_len != 4'(tsq_pkg::CMD_MAX))
            next_cmd_len = cmd_len + 4'h1;
        end
      end
      tsq_pkg::TSQ_ST_SEND:
      begin
        if (tx_ready)
        begin
          if (int'(pos) == reply_last(cmd, kind))
            next_state = tsq_pkg::TSQ_ST_RECV;
          else
            next_pos = pos + 8'h01;
        end
      end
      default:
        next_state = tsq_pkg::TSQ_ST_RECV;
    endcase
    // Character presented after this edge, from the values it will hold
    next_tx_data = reply_char(next_cmd, int'(next_pos), next_el_bcd,
                              next_az_bcd, next_lvl_bcd, next_q_bcd,
                              next_kind);
  end

  // Registers only; everything is cleared by reset
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= tsq_pkg::TSQ_ST_RECV;
      cmd <= tsq_pkg::TSQ_CMD_NONE;
      cmd_buf <= '0;
      cmd_len <= 4'h0;
      pos <= tsq_pkg::POS_RESET;
      el_bcd <= tsq_pkg::BCD_RESET;
      az_bcd <= tsq_pkg::BCD_RESET;
      lvl_bcd <= tsq_pkg::BCD_RESET;
      q_bcd <= tsq_pkg::BCD_RESET;
      kind <= 2'b00;
      tx_data <= 8'h00;
      quality_req <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cmd <= next_cmd;
      cmd_buf <= next_cmd_buf;
      cmd_len <= next_cmd_len;
      pos <= next_pos;
      el_bcd <= next_el_bcd;
      az_bcd <= next_az_bcd;
      lvl_bcd <= next_lvl_bcd;
      q_bcd <= next_q_bcd;
      kind <= next_kind;
      tx_data <= next_tx_data;
      quality_req <= next_quality_req;
    end
  end

endmodule

// >>> tsq_query_cmds_monitor.sv
// Port checks for the target and signal query command interpreter
module tsq_query_cmds_monitor (
  input wire logic clk_sys, // System clock
  input wire logic rstn, // Reset, active low
  input wire logic [7:0] rx_data, // Character in
  input wire logic rx_valid, // Character present
  input wire logic rx_ready, // Parser takes character
  input wire logic [7:0] tx_data, // Reply character
  input wire logic tx_valid, // Reply present
  input wire logic tx_ready, // Sink takes reply
  input wire logic quality_req // Receiver request pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  //////////////////////////////////////////////////////////////////////////
  // Steps of a transfer
  sequence s_cr_in;
    rx_valid && rx_ready && rx_data == tsq_pkg::CHAR_CR;
  endsequence
  sequence s_out(logic [7:0] c);
    tx_valid && tx_ready && tx_data == c;
  endsequence
  sequence s_end;
    s_out(tsq_pkg::CHAR_ACK) or s_out(tsq_pkg::CHAR_NAK);
  endsequence

  //////////////////////////////////////////////////////////////////////////
  // Framing of input and reply
  AST_CR_REPLY: assert property (s_cr_in |=> tx_valid && !rx_ready)
    else $error("No reply after carriage return");
  AST_OTHER_QUIET: assert property (rx_valid && rx_ready &&
    rx_data != tsq_pkg::CHAR_CR |=> !tx_valid && rx_ready)
    else $error("Reply started without carriage return");
  AST_RX_BLOCKED: assert property (tx_valid |-> !rx_ready)
    else $error("Input taken during reply");
  AST_CR_THEN_LF: assert property (s_out(tsq_pkg::CHAR_CR) |=>
    tx_valid && tx_data == tsq_pkg::CHAR_LF)
    else $error("Line feed does not follow carriage return");
  AST_LF_THEN_END: assert property (s_out(tsq_pkg::CHAR_LF) |=>
    tx_valid && (tx_data == tsq_pkg::CHAR_ACK ||
    tx_data == tsq_pkg::CHAR_NAK))
    else $error("Reply not closed by ack or nak");
  AST_END_IDLE: assert property (s_end |=> !tx_valid && rx_ready)
    else $error("Output continues after closing character");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data))
    else $error("Reply character changed while stalled");

  //////////////////////////////////////////////////////////////////////////
  // Receiver quality request
  AST_QREQ_ONE: assert property (quality_req |=> !quality_req)
    else $error("Quality request longer than one cycle");
  AST_QREQ_CAUSE: assert property (quality_req |->
    $past(rx_valid && rx_ready && rx_data == tsq_pkg::CHAR_CR))
    else $error("Quality request without carriage return");
  AST_QREQ_ACK: assert property (quality_req |->
    ##[0:600] s_out(tsq_pkg::CHAR_ACK))
    else $error("Quality request on a refused command");
endmodule

bind tsq_query_cmds tsq_query_cmds_monitor tsq_query_cmds_monitor_i (
  .clk_sys(clk_sys), .rstn(rstn), .rx_data(rx_data), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .quality_req(quality_req));

// >>> tsq_terminal.sv
// Maintenance terminal model: types commands, collects replies
module tsq_terminal (
  input wire logic clk_sys, // System clock
  output logic [7:0] rx_data, // Character to parser
  output logic rx_valid, // Character present
  input wire logic rx_ready, // Parser takes character
  input wire logic [7:0] tx_data, // Reply character
  input wire logic tx_valid, // Reply present
  output logic tx_ready // Terminal takes reply character
);
  timeunit 1ns;
  timeprecision 1ns;
  bit slow = 0;
  bit done = 0;
  string reply = "";

  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'hFF;
    tx_ready = 1'b1;
  end

  // Slow mode holds tx_ready low on every other cycle
  always @(negedge clk_sys) tx_ready <= slow ? ~tx_ready : 1'b1;

  // Gather reply text; the closing ack or nak ends it
  always @(posedge clk_sys)
  begin
    if (tx_valid && tx_ready)
    begin
      reply = {reply, string'(tx_data)};
      if (tx_data == 8'h3E || tx_data == 8'h3F) done = 1;
    end
  end

  // One line, closed by carriage return; only sent while parser idles
  task send(input string s);
    for (int i = 0; i <= s.len(); i++)
    begin
      @(negedge clk_sys);
      rx_valid = 1'b1;
      rx_data = (i == s.len()) ? tsq_pkg::CHAR_CR : s[i];
      // Hold the character until an edge at which the parser takes it
      @(posedge clk_sys);
      while (rx_ready !== 1'b1) @(posedge clk_sys);
    end
    @(negedge clk_sys);
    rx_valid = 1'b0;
    rx_data = ~rx_data; // Released line must not look like a character
  endtask
endmodule

// >>> tsq_query_cmds_test.sv
// Self-checking bench for the target and signal query commands
module tsq_query_cmds_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    int k; int m; string sfx; logic [13:0] el; logic [13:0] az;
    logic [11:0] raw; logic [15:0] gain; logic signed [13:0] off;
    logic [7:0] q; logic [1:0] kind; string exp; bit ack;
  } tsq_row_t;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] rx_data, tx_data;
  logic rx_valid, rx_ready, tx_valid, tx_ready, quality_req;
  logic [13:0] target_el = '0, target_az = '0;
  logic [11:0] rf_raw = '0;
  logic [15:0] rf_gain = '0;
  logic signed [13:0] rf_offset = '0;
  logic [7:0] quality_last = '0;
  logic [1:0] receiver_kind = '0;
  int error_cnt = 0, n_compared = 0, qreq_cnt = 0;
  // Keyword index, case mode (1 lower, 2 mixed, 3 line feed inside)
  tsq_row_t rows[15] = '{
    '{0,0,"",225,3506,0,0,0,0,0,"Target Location = E 225, A 3506",1},
    '{0,1,"",1500,12000,0,0,0,0,0,"Target Location = E 999, A 9999",1},
    '{1,2,"",0,0,100,512,-5,0,0,"Signal Strength = 0195",1},
    '{1,3,"",0,0,4095,65535,0,0,0,"Signal Strength = 9999",1},
    '{1,1,"",0,0,0,256,-5,0,0,"Signal Strength = 0000",1},
    '{2,0,"",0,0,0,0,0,7,0,"Stale Signal Quality = 07",1},
    '{2,2,"",0,0,0,0,0,200,0,"Stale Signal Quality = 99",1},
    '{3,0,"",0,0,0,0,0,0,0,"Receiver type has not been tested yet",1},
    '{3,0,"",0,0,0,0,0,0,1,"Receiver type is protocol A",1},
    '{3,2,"",0,0,0,0,0,0,2,"Receiver type is protocol B",1},
    '{3,1,"",0,0,0,0,0,0,3,"Receiver type cannot be determined",1},
    '{1,0,",5",0,0,0,0,0,0,0,"",0},
    '{2,0," 1",0,0,0,0,0,0,0,"",0},
    '{4,0,"",0,0,0,0,0,0,0,"",0},
    '{4,0,"HELLO",0,0,0,0,0,0,0,"",0}};

  always #50 clk_sys = ~clk_sys;
  // Count receiver requests as the receiver link would see them
  always @(posedge clk_sys) if (quality_req === 1'b1) qreq_cnt++;

  tsq_query_cmds tsq_query_cmds_i (.clk_sys(clk_sys), .rstn(rstn),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .target_el(target_el), .target_az(target_az), .rf_raw(rf_raw),
    .rf_gain(rf_gain), .rf_offset(rf_offset), .quality_last(quality_last),
    .receiver_kind(receiver_kind), .quality_req(quality_req));
  tsq_terminal tsq_terminal_i (.clk_sys(clk_sys), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready));

  //////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic string kw(input int k, input int m);
    logic [87:0] v;
    logic [7:0] c;
    int n;
    string s;
    s = "";
    v = '0;
    n = 0;
    case (k)
      0: begin v = tsq_pkg::KW_TARGET; n = 11; end
      1: begin v = 88'(tsq_pkg::KW_RF); n = 8; end
      2: begin v = 88'(tsq_pkg::KW_QUALITY); n = 10; end
      3: begin v = 88'(tsq_pkg::KW_KIND); n = 7; end
      default: n = 0;
    endcase
    for (int j = n - 1; j >= 0; j--)
    begin
      c = v[8*j +: 8];
      if (m == 1 || (m == 2 && j[0])) c = c | tsq_pkg::CASE_GAP;
      if (m == 3 && j == 3) s = {s, "\n"};
      s = {s, string'(c)};
    end
    return s;
  endfunction

  task cmp_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task cmp_str(input string got, input string exp);
    n_compared++;
    if (got != exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Drive the stores, send one command, check text and request count
  task run(input tsq_row_t r);
    int q0;
    int n;
    @(negedge clk_sys);
    {target_el, target_az, rf_raw, rf_gain} = {r.el, r.az, r.raw, r.gain};
    {rf_offset, quality_last, receiver_kind} = {r.off, r.q, r.kind};
    q0 = qreq_cnt;
    tsq_terminal_i.reply = "";
    tsq_terminal_i.done = 0;
    tsq_terminal_i.send({kw(r.k, r.m), r.sfx});
    for (n = 0; n < 400 && !tsq_terminal_i.done; n++) @(negedge clk_sys);
    // A reply that never closes is a failure in its own right
    if (!tsq_terminal_i.done) error_cnt++;
    cmp_str(tsq_terminal_i.reply, {r.exp, "\r\n", r.ack ? ">" : "?"});
    cmp_val(qreq_cnt - q0, (r.k == 2 && r.ack) ? 1 : 0);
  endtask

  task stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Watchdog: under a thousand cycles are expected, allow far more
  initial
  begin
    #2000000;
    error_cnt++;
    stop_test();
  end

  // Table, then stalled back-to-back queries and a reset mid-reply
  initial
  begin
    repeat (12) @(negedge clk_sys);
    // Idle outputs during reset: ready for input, no reply, no request
    cmp_val({tx_valid, rx_ready, quality_req, tx_data}, 11'h200);
    rstn = 1'b1;
    foreach (rows[i]) run(rows[i]);
    tsq_terminal_i.slow = 1;
    run(tsq_row_t'{2,1,"",0,0,0,0,0,42,0,"Stale Signal Quality = 42",1});
    run(tsq_row_t'{2,0,"",0,0,0,0,0,5,0,"Stale Signal Quality = 05",1});
    tsq_terminal_i.send(kw(3, 0));
    repeat (5) @(negedge clk_sys);
    rstn = 1'b0;
    @(negedge clk_sys);
    cmp_val({tx_valid, rx_ready, quality_req, tx_data}, 11'h200);
    rstn = 1'b1;
    run(rows[0]);
    stop_test();
  end
endmodule
